/* File: sync_clock_pin_pkg.sv */
// constants shared by the clock pin select block and its divider
package sync_clock_pin_pkg;

  // ==========================================
  // clock output pin selection codes
  localparam logic [1:0] SEL_MAIN_A    = 2'h0;
  localparam logic [1:0] SEL_MAIN_B    = 2'h1;
  localparam logic [1:0] SEL_RX_SHARED = 2'h2;
  localparam logic [1:0] SEL_FC_SHARED = 2'h3;

  // ==========================================
  // transfer framing and reset values
  localparam int          DATA_BITS      = 8;
  localparam logic [3:0]  HALF_FIRST     = 4'h0;
  localparam logic [3:0]  HALF_LAST      = 4'hF;
  localparam logic        TXD_RESET      = 1'b1;
  localparam logic        CLK_RESET      = 1'b1;
  localparam logic [7:0]  DATA_RESET     = 8'h00;
  localparam logic [7:0]  DIV_RESET      = 8'h00;
  localparam logic [1:0]  SEL_RESET      = 2'h0;

  // ==========================================
  // shift engine states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_SHIFT = 2'b10
  } xfer_state_t;

endpackage

/* File: baud_if.sv */
// carrier between the pin select block and its baud divider
`timescale 1ns/1ns
interface baud_if;
  logic       run;
  logic [7:0] reload;
  logic       tick;

  modport gen (input run, input reload, output tick);
  modport user (output run, output reload, input tick);
endinterface

/* File: baud_divider.sv */
// baud divider: one tick every reload plus one clocks while running
`timescale 1ns/1ns
module baud_divider
  import sync_clock_pin_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  baud_if.gen       bus
);

  // ==========================================
  // state
  typedef struct packed {
    logic [7:0] cnt;
  } div_state_t;

  div_state_t s_reg;
  div_state_t s_next;

  // ==========================================
  // count down, reload on zero
  assign bus.tick = bus.run && (s_reg.cnt == 8'h00);

  always_comb begin
    s_next = s_reg;
    if (!bus.run || (s_reg.cnt == 8'h00)) begin
      s_next.cnt = bus.reload;
    end else begin
      s_next.cnt = s_reg.cnt - 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_reg.cnt <= DIV_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================
  // checks
  property p_tick_period;
    @(posedge clk_sys) disable iff (!rst_n)
    (bus.tick && bus.run && $stable(bus.reload) && bus.reload == 8'h01) |=> !bus.tick ##1 (bus.tick || !bus.run);
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("divider tick spacing wrong");

endmodule

/* File: sync_clock_pin_select.sv */
// channel 0 clock-synchronous transmitter with selectable clock output pin
`timescale 1ns/1ns

// Notes on behaviour
// - With the internal clock selected the transfer clock leaves on exactly one of three pins.
// - The pin choice comes from a two-bit select field.
// - Codes 00 and 01 use the main pin, 10 the rx-shared pin, 11 the fc-shared pin, data always on transmit.
// - The main pin, when not carrying the clock, drives high for polarity 0 and low for polarity 1.
// - The rx-shared pin floats when port 8 line 2 is an input and otherwise drives the idle level with codes 01 and 11, the port 8 line 2 value with 00.
// - While the shared pins carry the clock, flow control is disabled, and so is reception except with the fc-shared pin and line 2 an input.
// - When the fc-shared pin is not a clock output it stays a general-purpose port line.
// - With main and fc-shared clocks and line 2 an input, received data is still taken.
// - The select is changed only after a transfer ends, and the data write starts the next one.
// - Switching pins between transfers lets one transmit line serve three receivers.
// - The transfer clock is the count source divided by two times the sum of reload and one.
// - Data leaves on the falling edge for polarity 0 and the rising edge for polarity 1.
module sync_clock_pin_select
  import sync_clock_pin_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       clock_source_external,
  input  wire logic       clock_polarity,
  input  wire logic [1:0] pin_select,
  input  wire logic [7:0] baud_divider,
  input  wire logic       flow_ctrl_disable,
  input  wire logic       flow_ctrl_in_n,
  input  wire logic       rx_enable,
  input  wire logic       tx_enable,
  input  wire logic       port8_dir_line0,
  input  wire logic       port8_dir_line2,
  input  wire logic       port8_line0,
  input  wire logic       port8_line2,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_data_write,
  input  wire logic       serial_receive_pin,
  output logic            serial_transmit_pin,
  output logic            main_xfer_clock_pin_o,
  output logic            main_xfer_clock_pin_oe_n,
  output logic            alt_clock_pin_rx_shared_o,
  output logic            alt_clock_pin_rx_shared_oe_n,
  output logic            alt_clock_pin_fc_shared_o,
  output logic            alt_clock_pin_fc_shared_oe_n,
  output logic            tx_buffer_empty,
  output logic            tx_reg_empty,
  output logic [7:0]      rx_data,
  output logic            rx_data_valid,
  output logic            reception_active,
  output logic            flow_ctrl_active
);

  // ==========================================
  // helpers
  function automatic logic idle_level(input logic pol);
    idle_level = ~pol;
  endfunction

  // ==========================================
  // state
  typedef struct packed {
    xfer_state_t st;
    logic [3:0]  half_cnt;
    logic        clk_level;
    logic        txd;
    logic [7:0]  tx_shift;
    logic [7:0]  tx_buf;
    logic        buf_full;
    logic        reg_empty;
    logic [7:0]  rx_shift;
    logic [7:0]  rx_word;
    logic        rx_done;
    logic [1:0]  sel;
  } pin_state_t;

  pin_state_t s_reg;
  pin_state_t s_next;

  baud_if baud ();

  baud_divider u_div (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .bus     (baud.gen)
  );

  // ==========================================
  // pin roles
  logic internal_clk;
  logic idle_now;
  logic shared_clocking;
  logic rx_pin_clocking;
  logic fc_clocking;
  logic rx_ok;
  logic fc_ok;
  logic start;

  always_comb begin
    internal_clk    = !clock_source_external;
    idle_now        = idle_level(clock_polarity);
    fc_clocking     = internal_clk && (s_reg.sel == SEL_FC_SHARED);
    rx_pin_clocking = internal_clk && ((s_reg.sel == SEL_RX_SHARED) ||
                      ((s_reg.sel != SEL_MAIN_A) && port8_dir_line2));
    shared_clocking = internal_clk && (s_reg.sel != SEL_MAIN_A);
    rx_ok           = rx_enable && !rx_pin_clocking;
    fc_ok           = !flow_ctrl_disable && !shared_clocking;
    start           = tx_enable && s_reg.buf_full && internal_clk && (!fc_ok || !flow_ctrl_in_n);
  end

  assign baud.run    = (s_reg.st == ST_SHIFT);
  assign baud.reload = baud_divider;

  // ==========================================
  // shift engine
  always_comb begin
    s_next = s_reg;
    s_next.rx_done = 1'b0;
    case (s_reg.st)
      ST_IDLE: begin
        s_next.clk_level = idle_now;
        s_next.half_cnt  = HALF_FIRST;
        s_next.sel       = pin_select;
        if (start) begin
          s_next.st        = ST_SHIFT;
          s_next.tx_shift  = s_reg.tx_buf;
          s_next.buf_full  = 1'b0;
          s_next.reg_empty = 1'b0;
        end
      end
      ST_SHIFT: begin
        if (baud.tick) begin
          s_next.clk_level = !s_reg.clk_level;
          s_next.half_cnt  = s_reg.half_cnt + 4'h1;
          if (s_reg.clk_level == idle_now) begin
            s_next.txd      = s_reg.tx_shift[0];
            s_next.tx_shift = {1'b0, s_reg.tx_shift[7:1]};
          end else begin
            if (rx_ok) begin
              s_next.rx_shift = {serial_receive_pin, s_reg.rx_shift[7:1]};
            end
            if (s_reg.half_cnt == HALF_LAST) begin
              if (rx_ok) begin
                s_next.rx_word = {serial_receive_pin, s_reg.rx_shift[7:1]};
                s_next.rx_done = 1'b1;
              end
              if (start && (pin_select == s_reg.sel)) begin
                s_next.tx_shift = s_reg.tx_buf;
                s_next.buf_full = 1'b0;
              end else begin
                s_next.st        = ST_IDLE;
                s_next.reg_empty = 1'b1;
                s_next.txd       = TXD_RESET;
              end
            end
          end
        end
      end
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase
    if (tx_data_write) begin
      s_next.tx_buf   = tx_data;
      s_next.buf_full = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_reg.st        <= ST_IDLE;
      s_reg.half_cnt  <= HALF_FIRST;
      s_reg.clk_level <= CLK_RESET;
      s_reg.txd       <= TXD_RESET;
      s_reg.tx_shift  <= DATA_RESET;
      s_reg.tx_buf    <= DATA_RESET;
      s_reg.buf_full  <= 1'b0;
      s_reg.reg_empty <= 1'b1;
      s_reg.rx_shift  <= DATA_RESET;
      s_reg.rx_word   <= DATA_RESET;
      s_reg.rx_done   <= 1'b0;
      s_reg.sel       <= SEL_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================
  // pin drivers
  always_comb begin
    main_xfer_clock_pin_oe_n = !internal_clk;
    main_xfer_clock_pin_o    = s_reg.sel[1] ? idle_now : s_reg.clk_level;
    if (internal_clk && (s_reg.sel == SEL_RX_SHARED)) begin
      alt_clock_pin_rx_shared_oe_n = 1'b0;
      alt_clock_pin_rx_shared_o    = s_reg.clk_level;
    end else if (internal_clk && (s_reg.sel == SEL_MAIN_B || s_reg.sel == SEL_FC_SHARED)) begin
      alt_clock_pin_rx_shared_oe_n = !port8_dir_line2;
      alt_clock_pin_rx_shared_o    = idle_now;
    end else begin
      alt_clock_pin_rx_shared_oe_n = !port8_dir_line2;
      alt_clock_pin_rx_shared_o    = port8_line2;
    end
    if (fc_clocking) begin
      alt_clock_pin_fc_shared_oe_n = 1'b0;
      alt_clock_pin_fc_shared_o    = s_reg.clk_level;
    end else begin
      alt_clock_pin_fc_shared_oe_n = !port8_dir_line0;
      alt_clock_pin_fc_shared_o    = port8_line0;
    end
  end

  assign serial_transmit_pin = s_reg.txd;
  assign tx_buffer_empty     = !s_reg.buf_full;
  assign tx_reg_empty        = s_reg.reg_empty;
  assign rx_data             = s_reg.rx_word;
  assign rx_data_valid       = s_reg.rx_done;
  assign reception_active    = rx_ok;
  assign flow_ctrl_active    = fc_ok;

  // ==========================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_start_xfer;
    (s_reg.st == ST_IDLE) && start;
  endsequence

  sequence s_in_shift;
    s_reg.st == ST_SHIFT;
  endsequence

  property p_one_clock_pin;
    internal_clk |-> ((s_reg.sel == SEL_FC_SHARED) == !alt_clock_pin_fc_shared_oe_n ||
                      s_reg.sel != SEL_FC_SHARED) && !main_xfer_clock_pin_oe_n;
  endproperty
  a_one_clock_pin: assert property (p_one_clock_pin) else $error("clock pin enable wrong");

  property p_sel_held;
    s_in_shift |-> $stable(s_reg.sel);
  endproperty
  a_sel_held: assert property (p_sel_held) else $error("select changed during transfer");

  property p_sel_taken;
    (s_reg.st == ST_IDLE) |=> (s_reg.sel == $past(pin_select));
  endproperty
  a_sel_taken: assert property (p_sel_taken) else $error("select not taken when idle");

  property p_main_idle;
    (internal_clk && s_reg.sel[1]) |-> (main_xfer_clock_pin_o == !clock_polarity);
  endproperty
  a_main_idle: assert property (p_main_idle) else $error("main pin idle level wrong");

  property p_rx_float;
    (!port8_dir_line2 && !(internal_clk && s_reg.sel == SEL_RX_SHARED)) |-> alt_clock_pin_rx_shared_oe_n;
  endproperty
  a_rx_float: assert property (p_rx_float) else $error("rx-shared pin not floating");

  property p_shared_blocks;
    (internal_clk && s_reg.sel == SEL_RX_SHARED) |-> (!reception_active && !flow_ctrl_active);
  endproperty
  a_shared_blocks: assert property (p_shared_blocks) else $error("rx or flow control left on");

  property p_rx_kept;
    (internal_clk && s_reg.sel == SEL_FC_SHARED && !port8_dir_line2 && rx_enable) |-> reception_active;
  endproperty
  a_rx_kept: assert property (p_rx_kept) else $error("reception blocked wrongly");

  property p_fc_gpio;
    (s_reg.sel != SEL_FC_SHARED) |-> (alt_clock_pin_fc_shared_oe_n == !port8_dir_line0 &&
                                      alt_clock_pin_fc_shared_o == port8_line0);
  endproperty
  a_fc_gpio: assert property (p_fc_gpio) else $error("fc-shared pin not a port line");

  property p_idle_rest;
    (s_reg.st == ST_IDLE) ##1 (s_reg.st == ST_IDLE && $stable(clock_polarity)) |->
      (s_reg.clk_level == !clock_polarity);
  endproperty
  a_idle_rest: assert property (p_idle_rest) else $error("idle clock level wrong");

  property p_start_clears;
    s_start_xfer |=> s_in_shift ##0 !s_reg.reg_empty;
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("transfer did not start");

  property p_lead_edge_data;
    ((s_reg.st == ST_SHIFT) && baud.tick && s_reg.clk_level == !clock_polarity && $stable(clock_polarity)) |=>
      (serial_transmit_pin == $past(s_reg.tx_shift[0]));
  endproperty
  a_lead_edge_data: assert property (p_lead_edge_data) else $error("data not on leading edge");

  property p_toggle;
    ((s_reg.st == ST_SHIFT) && baud.tick && !(s_reg.half_cnt == HALF_LAST && s_reg.clk_level != idle_now)) |=>
      (s_reg.clk_level != $past(s_reg.clk_level));
  endproperty
  a_toggle: assert property (p_toggle) else $error("clock did not toggle on tick");

endmodule

/* File: sync_rx_partner.sv */
// model of one clock-synchronous receiver hung on one clock output pin
`timescale 1ns/1ns
module sync_rx_partner (
  input  wire logic       sclk,
  input  wire logic       sdata,
  input  wire logic       polarity,
  input  wire logic       clear,
  input  wire logic [7:0] reply,
  output logic [7:0]      got,
  output logic [3:0]      count,
  output logic            sreply
);
  // ==========================================
  // sample on the trailing edge, answer on the leading edge
  wire logic samp = sclk ^ polarity;
  always @(posedge samp or posedge clear) begin
    if (clear) begin
      got   <= 8'h00;
      count <= 4'h0;
    end else begin
      got   <= {sdata, got[7:1]};
      count <= count + 4'h1;
    end
  end
  always @(negedge samp or posedge clear) begin
    if (clear)
      sreply <= reply[0];
    else
      sreply <= reply[count[2:0]];
  end
endmodule

/* File: tb_sync_clock_pin_select.sv */
// self-checking bench for the clock output pin select block
`timescale 1ns/1ns
`define CHECK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", nm, ex, gt); end end
module tb_sync_clock_pin_select;
  import sync_clock_pin_pkg::*;
  typedef struct {
    logic [1:0] sel;
    logic [7:0] data;
    int         half;
    logic [5:0] pins;
    logic       rxact;
    logic       fcact;
    logic [7:0] rxbyte;
  } note_t;
  logic       clk_sys = 1'b0, rst_n = 1'b0, pol = 1'b0, fc_dis = 1'b1, rx_en = 1'b0, clr = 1'b0;
  logic       cts_n = 1'b0;
  logic       dir0 = 1'b0, dir2 = 1'b1, line0 = 1'b1, line2 = 1'b0, wr = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [7:0] n = 8'h00, tx_byte = 8'h00, reply = 8'h00, rxd, got0, got1, got2, got_sel;
  logic       txd, m_o, m_oe_n, r_o, r_oe_n, f_o, f_oe_n, tbe, tre, rxv, rxact, fcact, rep0, rep2;
  wire logic  txd_dly;
  logic [3:0] cnt0, cnt1, cnt2;
  logic [31:0] seed = 32'h0000_2995;
  int         mismatches = 0, check_count = 0, cycles = 0, lowc = 0, rx_want = 0, rx_seen = 0;
  note_t      q[$];
  note_t      cur;
  logic       rx_on = 1'b0;
  logic [7:0] rx_exp = 8'h00;
  wire logic  m_w = m_oe_n ? 1'b1 : m_o;
  wire logic  r_w = r_oe_n ? 1'b1 : r_o;
  wire logic  f_w = f_oe_n ? 1'b1 : f_o;
  wire logic  rx_w = r_oe_n ? ((sel == 2'h3) ? rep2 : rep0) : r_o;
  // line delay: the receivers see the last bit before the data line returns high
  assign #5 txd_dly = txd;
  wire logic [5:0] pins = {m_oe_n, m_o & ~m_oe_n, r_oe_n, r_o & ~r_oe_n, f_oe_n, f_o & ~f_oe_n};

  // ==========================================
  // design and receivers
  sync_clock_pin_select uut (.clk_sys(clk_sys), .rst_n(rst_n), .clock_source_external(1'b0),
    .clock_polarity(pol), .pin_select(sel), .baud_divider(n), .flow_ctrl_disable(fc_dis),
    .flow_ctrl_in_n(cts_n), .rx_enable(rx_en), .tx_enable(1'b1), .port8_dir_line0(dir0),
    .port8_dir_line2(dir2), .port8_line0(line0), .port8_line2(line2), .tx_data(tx_byte),
    .tx_data_write(wr), .serial_receive_pin(rx_w), .serial_transmit_pin(txd),
    .main_xfer_clock_pin_o(m_o), .main_xfer_clock_pin_oe_n(m_oe_n), .alt_clock_pin_rx_shared_o(r_o),
    .alt_clock_pin_rx_shared_oe_n(r_oe_n), .alt_clock_pin_fc_shared_o(f_o),
    .alt_clock_pin_fc_shared_oe_n(f_oe_n), .tx_buffer_empty(tbe), .tx_reg_empty(tre), .rx_data(rxd),
    .rx_data_valid(rxv), .reception_active(rxact), .flow_ctrl_active(fcact));
  sync_rx_partner p0 (.sclk(m_w), .sdata(txd_dly), .polarity(pol), .clear(clr), .reply(reply),
    .got(got0), .count(cnt0), .sreply(rep0));
  sync_rx_partner p1 (.sclk(r_w), .sdata(txd_dly), .polarity(pol), .clear(clr), .reply(8'h00),
    .got(got1), .count(cnt1), .sreply());
  sync_rx_partner p2 (.sclk(f_w), .sdata(txd_dly), .polarity(pol), .clear(clr), .reply(reply),
    .got(got2), .count(cnt2), .sreply(rep2));
  assign got_sel = (sel < 2'h2) ? got0 : ((sel == 2'h2) ? got1 : got2);

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic wait_done;
    int k;
    k = 0;
    repeat (3) @(negedge clk_sys);
    while (tre !== 1'b1 && k < 2000) begin
      @(negedge clk_sys);
      k++;
    end
    repeat (4) @(negedge clk_sys);
  endtask

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  // ==========================================
  // watcher: one note per finished transfer
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish;
    end
    if (rst_n && tre === 1'b0)
      lowc++;
    if (rst_n && tre === 1'b1 && lowc > 0 && q.size() > 0) begin
      cur = q.pop_front();
      `CHECK("half_periods", cur.half, lowc)
      `CHECK("rx0_count", (cur.sel < 2'h2) ? 4'h8 : 4'h0, cnt0)
      `CHECK("rx1_count", (cur.sel == 2'h2) ? 4'h8 : 4'h0, cnt1)
      `CHECK("rx2_count", (cur.sel == 2'h3) ? 4'h8 : 4'h0, cnt2)
      `CHECK("byte_seen", cur.data, got_sel)
      `CHECK("idle_pins", cur.pins, pins)
      `CHECK("txd_idle", 1'b1, txd)
      `CHECK("reception_active", cur.rxact, rxact)
      `CHECK("flow_ctrl_active", cur.fcact, fcact)
      rx_on = cur.rxact;
      rx_exp = cur.rxbyte;
      lowc = 0;
    end
    if (rxv === 1'b1) begin
      rx_seen++;
      `CHECK("rx_pulse_expected", 1'b1, rx_on)
      `CHECK("rx_data", rx_exp, rxd)
    end
  end

  // ==========================================
  // driver
  initial begin
    note_t nt;
    repeat (6) @(negedge clk_sys);
    `CHECK("reset_txd", 1'b1, txd)
    `CHECK("reset_tre", 1'b1, tre)
    rst_n = 1'b1;
    for (int i = 0; i < 12; i++) begin
      @(negedge clk_sys);
      seed = xs(seed);
      sel = i[1:0];
      pol = i[2];
      n = {6'h00, seed[1:0]};
      dir2 = (sel == 2'h2) ? 1'b1 : seed[2];
      cts_n = (sel == 2'h0) ? 1'b0 : seed[7];
      dir0 = (sel == 2'h3) ? 1'b1 : seed[3];
      line0 = ~pol;
      line2 = seed[4];
      rx_en = seed[5];
      fc_dis = seed[6];
      tx_byte = seed[15:8];
      reply = seed[23:16];
      clr = 1'b1;
      nt.sel = sel;
      nt.data = tx_byte;
      nt.half = 16 * (n + 1);
      nt.rxact = rx_en & ((sel == 2'h0) | ((sel != 2'h2) & ~dir2));
      nt.fcact = ~fc_dis & (sel == 2'h0);
      nt.rxbyte = dir2 ? {8{line2}} : reply;
      nt.pins = {1'b0, ~pol, ~dir2, dir2 & ((sel == 2'h0) ? line2 : ~pol), ~dir0, ~pol & dir0};
      q.push_back(nt);
      if (nt.rxact)
        rx_want++;
      @(negedge clk_sys);
      clr = 1'b0;
      wr = 1'b1;
      @(negedge clk_sys);
      wr = 1'b0;
      wait_done();
      $display("test %0d done sel %0d", i, sel);
    end
    `CHECK("rx_pulses", rx_want, rx_seen)
    `CHECK("notes_left", 0, q.size())
    tally_and_finish;
  end
endmodule
